// >>> netcfg_pkg.sv
// constants and carrier types for the common configuration register bank
// assumes a single 100 MHz device clock and a byte-wide host register port
package netcfg_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets, multi-byte values stored most significant first
  localparam logic [15:0] SIP_OFS = 16'h000F;
  localparam logic [15:0] CAUSE_OFS = 16'h0015;
  localparam logic [15:0] MASK_OFS = 16'h0016;
  localparam logic [15:0] RETRY_TMO_OFS = 16'h0017;
  localparam logic [15:0] RETRY_LIM_OFS = 16'h0019;
  localparam logic [15:0] RXSZ_OFS = 16'h001A;
  localparam logic [15:0] TXSZ_OFS = 16'h001B;
  localparam logic [15:0] AUTH_OFS = 16'h001C;
  localparam logic [15:0] PTMR_OFS = 16'h0028;
  localparam logic [15:0] PMAG_OFS = 16'h0029;
  localparam logic [15:0] UIP_OFS = 16'h002A;
  localparam logic [15:0] UNR_PORT_OFS = 16'h002E;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt cause field positions
  localparam int CONFLICT_BIT = 7;
  localparam int UNREACHABLE_BIT = 6;
  localparam int PPP_CLOSE_BIT = 5;
  localparam int RSVD_CAUSE_BIT = 4;
  localparam logic [7:0] STICKY_MASK = 8'hE0;
  localparam int NUM_SOCK = 4;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [31:0] SIP_RST = 32'h0000_0000;
  localparam logic [7:0] CAUSE_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [15:0] RETRY_TMO_RST = 16'h07D0;
  localparam logic [7:0] RETRY_LIM_RST = 8'h08;
  localparam logic [7:0] BUFSZ_RST = 8'h55;
  localparam logic [15:0] AUTH_RST = 16'h0000;
  localparam logic [7:0] PTMR_RST = 8'h28;
  localparam logic [7:0] PMAG_RST = 8'h00;
  localparam logic [15:0] AUTH_PAP = 16'hC023;
  localparam logic [15:0] AUTH_CHAP = 16'hC223;
  localparam logic [4:0] POOL_KB = 5'h08;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int RETRY_UNIT_NS = 100000;
  localparam int LCP_UNIT_NS = 25000000;
  localparam int RETRY_UNIT_CYC = RETRY_UNIT_NS / CLK_PERIOD_NS;
  localparam int LCP_UNIT_CYC = LCP_UNIT_NS / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } host_req_t;

  typedef struct packed {
    logic conflict;
    logic unreachable;
    logic [31:0] unreachable_ip;
    logic [15:0] unreachable_port;
    logic ppp_closed;
    logic auth_valid;
    logic [15:0] auth_type;
  } engine_evt_t;

  typedef logic [NUM_SOCK-1:0][7:0] sock_intr_t;
  typedef logic [NUM_SOCK-1:0][3:0] alloc_kb_t;

endpackage

// >>> buf_alloc.sv
// ordered buffer allocator for one direction (rx or tx)
// assumes the size register comes from a flip-flop on the same clock
`timescale 1ns/1ps
module buf_alloc (
  input wire logic [7:0] size_code_i,
  output netcfg_pkg::alloc_kb_t alloc_kb_o
);

  function automatic logic [4:0] code_kb(input logic [1:0] code);
    code_kb = 5'(5'h01 << code);
  endfunction

  logic [4:0] used;
  logic [4:0] req;

  always_comb begin
    used = 5'h00;
    req = 5'h00;
    alloc_kb_o = '0;
    for (int i = 0; i < netcfg_pkg::NUM_SOCK; i++) begin
      req = code_kb(size_code_i[2*i +: 2]);
      if (5'(used + req) <= netcfg_pkg::POOL_KB && used <= netcfg_pkg::POOL_KB) begin
        alloc_kb_o[i] = req[3:0];
        used = 5'(used + req);
      end else begin
        // no room left: socket gets nothing and must stay unused
        alloc_kb_o[i] = 4'h0;
        used = 5'h10;
      end
    end
  end

endmodule

// >>> netcfg_regs.sv
// common configuration and status register bank with interrupt cause logic
// assumes host port, engine events and socket registers share sys_clk_i
`timescale 1ns/1ps

// Operation
// - arp request with own ip sets conflict
// - sticky cause bits clear on written one
// - unreachable captures ip, port, sets bit6
// - pppoe session close sets bit5
// - interrupt low while any enabled cause
// - mask bit gates matching cause bit
// - retransmit when peer silent or late
// - retries beyond limit raise socket timeout
// - rx size two bits per socket
// - ordered allocation from 8KB pool
// - tx size same encoding, reset 0x55
// - auth type reports pap or chap
// - lcp echo every interval times 25ms
// - magic number register used in lcp
// - multi-byte values most significant first
// - ppp logic active only when enabled
module netcfg_regs #(
  parameter int unsigned RETRY_UNIT_CYC = netcfg_pkg::RETRY_UNIT_CYC,
  parameter int unsigned LCP_UNIT_CYC = netcfg_pkg::LCP_UNIT_CYC
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic sw_rst_i,
  input wire logic pppoe_enable_i,
  input wire netcfg_pkg::host_req_t host_req_i,
  output logic [7:0] host_rdata_o,
  input wire netcfg_pkg::engine_evt_t evt_i,
  input wire netcfg_pkg::sock_intr_t socket_intr_i,
  input wire logic retx_arm_i,
  input wire logic [1:0] retx_sock_i,
  input wire logic retx_ack_i,
  output logic int_n_o,
  output logic [31:0] source_ip_o,
  output logic retransmit_o,
  output logic retx_timeout_o,
  output logic [1:0] timeout_sock_o,
  output logic lcp_echo_req_o,
  output logic [7:0] lcp_magic_o,
  output netcfg_pkg::alloc_kb_t rx_alloc_kb_o,
  output netcfg_pkg::alloc_kb_t tx_alloc_kb_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef enum logic [1:0] {
    RT_IDLE = 2'b00,
    RT_WAIT = 2'b01,
    RT_EXPIRE = 2'b11
  } retx_state_t;

  typedef struct packed {
    logic [31:0] sip;
    logic [7:0] cause;
    logic [7:0] mask;
    logic [15:0] retry_tmo;
    logic [7:0] retry_lim;
    logic [7:0] rxsz;
    logic [7:0] txsz;
    logic [15:0] auth_type;
    logic [7:0] ptmr;
    logic [7:0] pmag;
    logic [31:0] uip;
    logic [15:0] unr_port;
    logic [7:0] rdata;
    logic int_n;
    retx_state_t rt_state;
    logic [1:0] rt_sock;
    logic [15:0] rt_pre;
    logic [15:0] rt_units;
    logic [7:0] rt_tries;
    logic retx;
    logic tmo;
    logic [23:0] lcp_pre;
    logic [7:0] lcp_units;
    logic lcp_req;
  } state_t;

  localparam state_t STATE_RST = '{
    sip: netcfg_pkg::SIP_RST, cause: netcfg_pkg::CAUSE_RST, mask: netcfg_pkg::MASK_RST,
    retry_tmo: netcfg_pkg::RETRY_TMO_RST, retry_lim: netcfg_pkg::RETRY_LIM_RST,
    rxsz: netcfg_pkg::BUFSZ_RST, txsz: netcfg_pkg::BUFSZ_RST, auth_type: netcfg_pkg::AUTH_RST,
    ptmr: netcfg_pkg::PTMR_RST, pmag: netcfg_pkg::PMAG_RST, uip: 32'h0000_0000,
    unr_port: 16'h0000, rdata: 8'h00,
    int_n: 1'b1, rt_state: RT_IDLE, rt_sock: 2'h0, rt_pre: 16'h0000,
    rt_units: 16'h0000, rt_tries: 8'h00, retx: 1'b0, tmo: 1'b0,
    lcp_pre: 24'h00_0000, lcp_units: 8'h00, lcp_req: 1'b0
  };

  // prescalers are 16 and 24 bits wide, so the unit counts must fit them
  localparam logic [15:0] RT_PRE_LAST = 16'(RETRY_UNIT_CYC - 1);
  localparam logic [23:0] LCP_PRE_LAST = 24'(LCP_UNIT_CYC - 1);

  state_t st_ff;
  state_t nxt_st;
  logic [1:0] rst_sync_ff;
  logic rst_n;
  logic [7:0] cause_vec;
  logic [7:0] set_vec;
  logic [7:0] clr_vec;
  logic [3:0] sock_pend;

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_ff[1];

  ////////////////////////////////////////////////////////////////////////////
  // interrupt cause view

  always_comb begin
    for (int i = 0; i < netcfg_pkg::NUM_SOCK; i++) begin
      sock_pend[i] = |socket_intr_i[i];
    end
    cause_vec = {st_ff.cause[7:5], 1'b0, sock_pend};
    set_vec = 8'h00;
    set_vec[netcfg_pkg::CONFLICT_BIT] = evt_i.conflict;
    set_vec[netcfg_pkg::UNREACHABLE_BIT] = evt_i.unreachable;
    set_vec[netcfg_pkg::PPP_CLOSE_BIT] = evt_i.ppp_closed & pppoe_enable_i;
    clr_vec = 8'h00;
    if (host_req_i.wr && host_req_i.addr == netcfg_pkg::CAUSE_OFS) begin
      clr_vec = host_req_i.wdata & netcfg_pkg::STICKY_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    nxt_st = st_ff;
    nxt_st.retx = 1'b0;
    nxt_st.tmo = 1'b0;
    nxt_st.lcp_req = 1'b0;

    nxt_st.cause = ((st_ff.cause & ~clr_vec) | set_vec) & netcfg_pkg::STICKY_MASK;

    if (evt_i.unreachable) begin
      nxt_st.uip = evt_i.unreachable_ip;
      nxt_st.unr_port = evt_i.unreachable_port;
    end
    if (evt_i.auth_valid && pppoe_enable_i) begin
      nxt_st.auth_type = evt_i.auth_type;
    end

    // byte lanes, high byte at lowest offset
    if (host_req_i.wr) begin
      for (int k = 0; k < 4; k++) begin
        if (host_req_i.addr == 16'(netcfg_pkg::SIP_OFS + 16'(k))) begin
          nxt_st.sip[8*(3-k) +: 8] = host_req_i.wdata;
        end
      end
      for (int k = 0; k < 2; k++) begin
        if (host_req_i.addr == 16'(netcfg_pkg::RETRY_TMO_OFS + 16'(k))) begin
          nxt_st.retry_tmo[8*(1-k) +: 8] = host_req_i.wdata;
        end
      end
      case (host_req_i.addr)
        // bit4 is stored as written; the host keeps it zero
        netcfg_pkg::MASK_OFS: nxt_st.mask = host_req_i.wdata;
        netcfg_pkg::RETRY_LIM_OFS: nxt_st.retry_lim = host_req_i.wdata;
        netcfg_pkg::RXSZ_OFS: nxt_st.rxsz = host_req_i.wdata;
        netcfg_pkg::TXSZ_OFS: nxt_st.txsz = host_req_i.wdata;
        netcfg_pkg::PTMR_OFS: nxt_st.ptmr = host_req_i.wdata;
        netcfg_pkg::PMAG_OFS: nxt_st.pmag = host_req_i.wdata;
        default: nxt_st.rdata = st_ff.rdata;
      endcase
    end

    if (host_req_i.rd) begin
      nxt_st.rdata = 8'h00;
      for (int k = 0; k < 4; k++) begin
        if (host_req_i.addr == 16'(netcfg_pkg::SIP_OFS + 16'(k))) begin
          nxt_st.rdata = st_ff.sip[8*(3-k) +: 8];
        end
        if (host_req_i.addr == 16'(netcfg_pkg::UIP_OFS + 16'(k))) begin
          nxt_st.rdata = st_ff.uip[8*(3-k) +: 8];
        end
      end
      for (int k = 0; k < 2; k++) begin
        if (host_req_i.addr == 16'(netcfg_pkg::RETRY_TMO_OFS + 16'(k))) begin
          nxt_st.rdata = st_ff.retry_tmo[8*(1-k) +: 8];
        end
        if (host_req_i.addr == 16'(netcfg_pkg::AUTH_OFS + 16'(k))) begin
          nxt_st.rdata = st_ff.auth_type[8*(1-k) +: 8];
        end
        if (host_req_i.addr == 16'(netcfg_pkg::UNR_PORT_OFS + 16'(k))) begin
          nxt_st.rdata = st_ff.unr_port[8*(1-k) +: 8];
        end
      end
      case (host_req_i.addr)
        netcfg_pkg::CAUSE_OFS: nxt_st.rdata = cause_vec;
        netcfg_pkg::MASK_OFS: nxt_st.rdata = st_ff.mask;
        netcfg_pkg::RETRY_LIM_OFS: nxt_st.rdata = st_ff.retry_lim;
        netcfg_pkg::RXSZ_OFS: nxt_st.rdata = st_ff.rxsz;
        netcfg_pkg::TXSZ_OFS: nxt_st.rdata = st_ff.txsz;
        netcfg_pkg::PTMR_OFS: nxt_st.rdata = st_ff.ptmr;
        netcfg_pkg::PMAG_OFS: nxt_st.rdata = st_ff.pmag;
        default: nxt_st.rdata = nxt_st.rdata;
      endcase
    end

    nxt_st.int_n = ~|(cause_vec & st_ff.mask);

    case (st_ff.rt_state)
      RT_IDLE: begin
        nxt_st.rt_pre = 16'h0000;
        nxt_st.rt_units = 16'h0000;
      end
      RT_WAIT: begin
        if (st_ff.rt_pre == RT_PRE_LAST) begin
          nxt_st.rt_pre = 16'h0000;
          nxt_st.rt_units = 16'(st_ff.rt_units + 16'h0001);
          // a zero period is treated as a single unit
          if (16'(st_ff.rt_units + 16'h0001) >= st_ff.retry_tmo) begin
            nxt_st.rt_state = RT_EXPIRE;
          end
        end else begin
          nxt_st.rt_pre = 16'(st_ff.rt_pre + 16'h0001);
        end
      end
      RT_EXPIRE: begin
        nxt_st.rt_pre = 16'h0000;
        nxt_st.rt_units = 16'h0000;
        if (st_ff.rt_tries >= st_ff.retry_lim) begin
          nxt_st.tmo = 1'b1;
          nxt_st.rt_state = RT_IDLE;
        end else begin
          nxt_st.retx = 1'b1;
          nxt_st.rt_tries = 8'(st_ff.rt_tries + 8'h01);
          nxt_st.rt_state = RT_WAIT;
        end
      end
      default: nxt_st.rt_state = RT_IDLE;
    endcase
    // a fresh command restarts the wait; an answer ends it
    if (retx_arm_i) begin
      nxt_st.rt_state = RT_WAIT;
      nxt_st.rt_sock = retx_sock_i;
      nxt_st.rt_pre = 16'h0000;
      nxt_st.rt_units = 16'h0000;
      nxt_st.rt_tries = 8'h00;
    end else if (retx_ack_i) begin
      nxt_st.rt_state = RT_IDLE;
    end

    // echo timer runs only in pppoe mode
    if (!pppoe_enable_i || st_ff.ptmr == 8'h00) begin
      nxt_st.lcp_pre = 24'h00_0000;
      nxt_st.lcp_units = 8'h00;
    end else if (st_ff.lcp_pre == LCP_PRE_LAST) begin
      nxt_st.lcp_pre = 24'h00_0000;
      if (8'(st_ff.lcp_units + 8'h01) >= st_ff.ptmr) begin
        nxt_st.lcp_units = 8'h00;
        nxt_st.lcp_req = 1'b1;
      end else begin
        nxt_st.lcp_units = 8'(st_ff.lcp_units + 8'h01);
      end
    end else begin
      nxt_st.lcp_pre = 24'(st_ff.lcp_pre + 24'h00_0001);
    end

    if (sw_rst_i) begin
      nxt_st = STATE_RST;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= STATE_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign host_rdata_o = st_ff.rdata;
  assign int_n_o = st_ff.int_n;
  assign source_ip_o = st_ff.sip;
  assign retransmit_o = st_ff.retx;
  assign retx_timeout_o = st_ff.tmo;
  assign timeout_sock_o = st_ff.rt_sock;
  assign lcp_echo_req_o = st_ff.lcp_req;
  assign lcp_magic_o = st_ff.pmag;

  buf_alloc u_rx_alloc (
    .size_code_i(st_ff.rxsz),
    .alloc_kb_o(rx_alloc_kb_o)
  );

  buf_alloc u_tx_alloc (
    .size_code_i(st_ff.txsz),
    .alloc_kb_o(tx_alloc_kb_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks

  conflict_set_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n)
    evt_i.conflict && !sw_rst_i |=> st_ff.cause[netcfg_pkg::CONFLICT_BIT] ##1 !int_n_o
      || !st_ff.mask[netcfg_pkg::CONFLICT_BIT])
    else $error("conflict event did not set its cause bit");

  sticky_hold_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n)
    st_ff.cause[netcfg_pkg::UNREACHABLE_BIT] && !sw_rst_i
      && !(host_req_i.wr && host_req_i.addr == netcfg_pkg::CAUSE_OFS)
      |=> st_ff.cause[netcfg_pkg::UNREACHABLE_BIT])
    else $error("sticky cause bit cleared without a host write");

  unreachable_capture_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n)
    evt_i.unreachable && !sw_rst_i |=> st_ff.uip == $past(evt_i.unreachable_ip)
      && st_ff.unr_port == $past(evt_i.unreachable_port)
      && st_ff.cause[netcfg_pkg::UNREACHABLE_BIT])
    else $error("unreachable address not captured");

  ppp_gate_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n)
    !pppoe_enable_i && !st_ff.cause[netcfg_pkg::PPP_CLOSE_BIT]
      |=> !st_ff.cause[netcfg_pkg::PPP_CLOSE_BIT] && !lcp_echo_req_o)
    else $error("ppp activity while pppoe mode is off");

  socket_pend_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n)
    socket_intr_i[0] != 8'h00 && st_ff.mask[0] && !sw_rst_i |=> !int_n_o)
    else $error("socket pending interrupt not signalled");

  int_release_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n)
    1'b1 |=> int_n_o == ($past(sw_rst_i) || $past(cause_vec & st_ff.mask) == 8'h00))
    else $error("interrupt pin disagrees with enabled causes");

  mask_gate_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n)
    st_ff.mask == 8'h00 && !(host_req_i.wr && host_req_i.addr == netcfg_pkg::MASK_OFS)
      |=> int_n_o)
    else $error("interrupt raised with every mask bit clear");

  set_wins_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n)
    evt_i.conflict && !sw_rst_i && host_req_i.wr && host_req_i.addr == netcfg_pkg::CAUSE_OFS
      |=> st_ff.cause[netcfg_pkg::CONFLICT_BIT])
    else $error("clear beat a same-cycle set");

  rsvd_read_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n)
    host_req_i.rd && host_req_i.addr == netcfg_pkg::CAUSE_OFS
      |=> !host_rdata_o[netcfg_pkg::RSVD_CAUSE_BIT])
    else $error("reserved cause bit read as one");

  soft_defaults_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n)
    sw_rst_i |=> st_ff.retry_tmo == 16'h07D0 && st_ff.retry_lim == 8'h08 && st_ff.rxsz == 8'h55
      && st_ff.txsz == 8'h55 && st_ff.ptmr == 8'h28)
    else $error("soft reset left a non-default value");

  msb_first_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n)
    host_req_i.rd && host_req_i.addr == netcfg_pkg::RETRY_TMO_OFS && !sw_rst_i
      |=> host_rdata_o == $past(st_ff.retry_tmo[15:8]))
    else $error("timeout high byte not at lowest offset");

  retry_limit_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n)
    retx_timeout_o |-> $past(st_ff.rt_state == RT_EXPIRE && st_ff.rt_tries >= st_ff.retry_lim))
    else $error("timeout raised before retries ran out");

  retx_space_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n)
    retransmit_o |-> $past(st_ff.rt_state == RT_EXPIRE) ##1 !retransmit_o)
    else $error("retransmit pulses back to back");

  auth_latch_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n)
    evt_i.auth_valid && pppoe_enable_i && !sw_rst_i |=> st_ff.auth_type == $past(evt_i.auth_type))
    else $error("auth type not latched");

  echo_pulse_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n)
    lcp_echo_req_o |-> st_ff.lcp_units == 8'h00 && st_ff.lcp_pre == 24'h00_0000)
    else $error("echo request off its interval");

endmodule

// >>> host_model.sv
// host processor model driving the byte-wide register port
// assumes the bench calls its tasks only after reset has been released
`timescale 1ns/1ps
module host_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output netcfg_pkg::host_req_t req_o
);
  initial req_o = '0;

  ////////////////////////////////////////////////////////////////////////////
  // one strobe cycle per access, request changed only at the falling edge
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_i);
    req_o = '{wr: 1'b1, rd: 1'b0, addr: a,
              wdata: (a == netcfg_pkg::MASK_OFS) ? (d & 8'hEF) : d};
    @(negedge clk_i);
    // idle bus shows inverted values so a stale address cannot look valid
    req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge clk_i);
    req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk_i);
    req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
    d = rdata_i;
  endtask
endmodule

// >>> netcfg_regs_tb.sv
// self-checking bench for the common register bank
// assumes short timer units so the retry and echo timers finish quickly
`timescale 1ns/1ps
module netcfg_regs_tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic sw_rst = 1'b0;
  logic pppoe = 1'b0;
  logic arm = 1'b0;
  logic ack = 1'b0;
  logic [1:0] rsock = 2'h0;
  netcfg_pkg::host_req_t req;
  netcfg_pkg::engine_evt_t evt = '0;
  netcfg_pkg::sock_intr_t sock_intr = '0;
  netcfg_pkg::alloc_kb_t rx_alloc, tx_alloc;
  logic [7:0] rdata, magic;
  logic [31:0] sip;
  logic int_n, retx, tmo, lcp;
  logic [1:0] tsock;
  int bad_count = 0;
  int total_checks = 0;
  int nretx = 0;
  int ntmo = 0;
  time lcp_last = 0;
  time lcp_prev = 0;
  logic [15:0] ofs [12] = '{16'h0017, 16'h0018, 16'h0019, 16'h001A, 16'h001B, 16'h0028,
                           16'h0015, 16'h0016, 16'h000F, 16'h001C, 16'h0029, 16'h002E};
  logic [7:0] rv [12] = '{8'h07, 8'hD0, 8'h08, 8'h55, 8'h55, 8'h28,
                         8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [15:0] auth [2] = '{16'hC223, 16'hC023};

  always #5 clk = ~clk;

  host_model host (.clk_i(clk), .rdata_i(rdata), .req_o(req));

  netcfg_regs #(.RETRY_UNIT_CYC(4), .LCP_UNIT_CYC(8)) dut (
    .sys_clk_i(clk), .nrst_i(nrst), .sw_rst_i(sw_rst), .pppoe_enable_i(pppoe),
    .host_req_i(req), .host_rdata_o(rdata), .evt_i(evt), .socket_intr_i(sock_intr),
    .retx_arm_i(arm), .retx_sock_i(rsock), .retx_ack_i(ack), .int_n_o(int_n),
    .source_ip_o(sip), .retransmit_o(retx), .retx_timeout_o(tmo),
    .timeout_sock_o(tsock), .lcp_echo_req_o(lcp), .lcp_magic_o(magic),
    .rx_alloc_kb_o(rx_alloc), .tx_alloc_kb_o(tx_alloc));

  always @(posedge clk) begin
    if (retx) nretx <= nretx + 1;
    if (tmo) ntmo <= ntmo + 1;
    if (lcp) begin
      lcp_prev <= lcp_last;
      lcp_last <= $time;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rc(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    chk({24'h0, d}, {24'h0, e});
  endtask

  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // whole run is well under 2000 cycles
  initial begin
    #50us;
    bad_count++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk) nrst = 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 12; i++) rc(ofs[i], rv[i]);
    for (int i = 0; i < 4; i++) host.wr(16'h000F + 16'(i), 8'(32'hC0A80003 >> (24 - 8 * i)));
    chk(sip, 32'hC0A80003);
    host.wr(netcfg_pkg::MASK_OFS, 8'hFF);
    rc(netcfg_pkg::MASK_OFS, 8'hEF);
    @(negedge clk) evt.conflict = 1'b1;
    @(negedge clk) evt = '0;
    rc(netcfg_pkg::CAUSE_OFS, 8'h80);
    chk({31'h0, int_n}, 32'h0);
    fork
      host.wr(netcfg_pkg::CAUSE_OFS, 8'h80);
      begin
        @(negedge clk) evt.conflict = 1'b1;
        @(negedge clk) evt = '0;
      end
    join
    rc(netcfg_pkg::CAUSE_OFS, 8'h80);
    host.wr(netcfg_pkg::CAUSE_OFS, 8'h80);
    rc(netcfg_pkg::CAUSE_OFS, 8'h00);
    chk({31'h0, int_n}, 32'h1);
    @(negedge clk) evt = '{unreachable: 1'b1, unreachable_ip: 32'hC0A8000B,
                           unreachable_port: 16'h1388, default: '0};
    @(negedge clk) evt = '0;
    for (int i = 0; i < 6; i++) rc(16'h002A + 16'(i), 8'(48'hC0A8000B1388 >> (40 - 8 * i)));
    rc(netcfg_pkg::CAUSE_OFS, 8'h40);
    chk({31'h0, int_n}, 32'h0);
    host.wr(netcfg_pkg::MASK_OFS, 8'h80);
    // the pin follows the mask one cycle after the write lands
    @(negedge clk);
    chk({31'h0, int_n}, 32'h1);
    host.wr(netcfg_pkg::CAUSE_OFS, 8'h40);
    @(negedge clk) evt.ppp_closed = 1'b1;
    @(negedge clk) evt = '0;
    rc(netcfg_pkg::CAUSE_OFS, 8'h00);
    pppoe = 1'b1;
    @(negedge clk) evt.ppp_closed = 1'b1;
    @(negedge clk) evt = '0;
    rc(netcfg_pkg::CAUSE_OFS, 8'h20);
    for (int i = 0; i < 2; i++) begin
      @(negedge clk) evt = '{auth_valid: 1'b1, auth_type: auth[i], default: '0};
      @(negedge clk) evt = '0;
      rc(16'h001C, auth[i][15:8]);
      rc(16'h001D, auth[i][7:0]);
    end
    host.wr(netcfg_pkg::CAUSE_OFS, 8'h30);
    rc(netcfg_pkg::CAUSE_OFS, 8'h00);
    sock_intr[0] = 8'h01;
    rc(netcfg_pkg::CAUSE_OFS, 8'h01);
    chk({31'h0, int_n}, 32'h1);
    host.wr(netcfg_pkg::MASK_OFS, 8'h01);
    @(negedge clk);
    chk({31'h0, int_n}, 32'h0);
    sock_intr = '0;
    rc(netcfg_pkg::CAUSE_OFS, 8'h00);
    chk({31'h0, int_n}, 32'h1);
    host.wr(netcfg_pkg::RXSZ_OFS, 8'hAA);
    chk({16'h0, rx_alloc}, 32'h0044);
    host.wr(netcfg_pkg::TXSZ_OFS, 8'h1B);
    chk({16'h0, tx_alloc}, 32'h0008);
    host.wr(netcfg_pkg::PMAG_OFS, 8'h5A);
    chk({24'h0, magic}, 32'h5A);
    host.wr(16'h0017, 8'h00);
    host.wr(16'h0018, 8'h01);
    host.wr(netcfg_pkg::RETRY_LIM_OFS, 8'h01);
    @(negedge clk) begin
      arm = 1'b1;
      rsock = 2'h2;
    end
    @(negedge clk) arm = 1'b0;
    repeat (40) @(posedge clk);
    chk(32'(nretx), 32'h1);
    chk(32'(ntmo), 32'h1);
    chk({30'h0, tsock}, 32'h2);
    @(negedge clk) arm = 1'b1;
    @(negedge clk) arm = 1'b0;
    @(negedge clk) ack = 1'b1;
    @(negedge clk) ack = 1'b0;
    repeat (40) @(posedge clk);
    chk(32'(nretx + ntmo), 32'h2);
    host.wr(netcfg_pkg::PTMR_OFS, 8'h02);
    repeat (60) @(posedge clk);
    chk(32'(lcp_last - lcp_prev), 32'h0000_00A0);
    @(negedge clk) sw_rst = 1'b1;
    @(negedge clk) sw_rst = 1'b0;
    rc(netcfg_pkg::RETRY_LIM_OFS, 8'h08);
    print_verdict();
  end
endmodule
